/* File: interrupt_vector_map.sv */
// Notes on behaviour
// - priority follows vector address: timebase lowest, reset vector highest
// - vector fetched as two bytes: high at even address, low at odd
// - spi transmit uses the vector at FFDE, spi receive at FFE0
// - conversion complete uses FFE2, keyboard uses FFE4
// - serial transmit FFE6, serial receive FFE8, serial error FFEA
// - second timer: overflow FFEC, channel 1 FFEE, channel 0 FFF0
// - first timer: overflow FFF2, channel 1 FFF4, channel 0 FFF6
// - clock monitor FFF8, external pin FFFA, software interrupt FFFC
`timescale 1ns/1ps
`include "ivm_map.svh"

module interrupt_vector_map (
  input  wire logic        clk,          // system clock, 25 MHz
  input  wire logic        srst,         // synchronous reset, active high
  // ahb-lite slave
  input  wire logic        hsel,         // slave select
  input  wire logic [31:0] haddr,        // byte address
  input  wire logic [1:0]  htrans,       // transfer type
  input  wire logic        hwrite,       // write when high
  input  wire logic [2:0]  hsize,        // word only
  input  wire logic [31:0] hwdata,       // write data
  input  wire logic        hready,       // bus ready
  output logic      [31:0] hrdata,       // read data
  output logic             hreadyout,    // slave ready
  output logic             hresp,        // always okay
  // interrupt sources
  input  wire logic        extIrqPin,    // external interrupt pin, level
  input  wire logic [14:0] onChipReq,    // on-chip requests, bit k-2 is flag k
  input  wire logic        swiReq,       // software interrupt pulse from core
  // vector fetch towards the core and memory
  input  wire logic        vecFetchReq,  // core asks for a vector, pulse
  output logic      [15:0] memAddr,      // vector byte address
  output logic             memRd,        // byte read strobe
  input  wire logic [7:0]  memData,      // byte, valid cycle after strobe
  output logic      [15:0] vector,       // assembled vector
  output logic             vectorValid,  // one-cycle pulse
  output logic             irq           // level interrupt to the core
);

  // ****************************************************************
  // source capture
  // ****************************************************************
  ivm_pkg::ivm_state_t st_reg;
  ivm_pkg::ivm_state_t st_next;

  logic        extIrqSync;
  logic [15:0] flagNow;
  logic [17:0] pendByIdx;
  logic [4:0]  winIdx;
  logic        winValid;

  // the pin is asynchronous; on-chip requests share our clock
  pin_sync u_ext_sync (
    .clk      (clk),
    .srst     (srst),
    .pinIn    (extIrqPin),
    .levelOut (extIrqSync)
  );

  // flag bit k-1 holds flag k
  assign flagNow = {onChipReq, extIrqSync};

  // ****************************************************************
  // priority over pending, unmasked sources
  // ****************************************************************
  generate
    for (genvar g = 0; g < 16; g++) begin : g_idx
      assign pendByIdx[g] = st_reg.flag[15 - g] & st_reg.mask[15 - g];
    end
  endgenerate
  assign pendByIdx[`IVM_SRC_SWI]   = st_reg.swiPend;
  assign pendByIdx[`IVM_SRC_RESET] = st_reg.resetPend;

  prio_pick u_pick (
    .req      (pendByIdx),
    .winIdx   (winIdx),
    .winValid (winValid)
  );

  // ****************************************************************
  // vector table
  // ****************************************************************
  function automatic logic [15:0] vecOf(input logic [4:0] idx);
    logic [15:0] v;
    v = `IVM_VEC_RESET;
    unique case (idx)
      5'h00: v = `IVM_VEC_TIMEBASE;
      5'h01: v = `IVM_VEC_SPI_TX;
      5'h02: v = `IVM_VEC_SPI_RX;
      5'h03: v = `IVM_VEC_ADC_DONE;
      5'h04: v = `IVM_VEC_KEYBOARD;
      5'h05: v = `IVM_VEC_SER_TX;
      5'h06: v = `IVM_VEC_SER_RX;
      5'h07: v = `IVM_VEC_SER_ERR;
      5'h08: v = `IVM_VEC_TB_OVF;
      5'h09: v = `IVM_VEC_TB_CH1;
      5'h0A: v = `IVM_VEC_TB_CH0;
      5'h0B: v = `IVM_VEC_TA_OVF;
      5'h0C: v = `IVM_VEC_TA_CH1;
      5'h0D: v = `IVM_VEC_TA_CH0;
      5'h0E: v = `IVM_VEC_CLK_MON;
      5'h0F: v = `IVM_VEC_EXT_IRQ;
      5'h10: v = `IVM_VEC_SWI;
      5'h11: v = `IVM_VEC_RESET;
      default: v = `IVM_VEC_RESET;
    endcase
    return v;
  endfunction : vecOf

  // ****************************************************************
  // register read mux
  // ****************************************************************
  function automatic logic [31:0] readOf(input logic [29:0] idx,
                                         input ivm_pkg::ivm_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == {14'h0000, `IVM_IDX_FLAGS_A}) begin
      d = {24'h00_0000, s.flag[5:0], 2'b00};
    end else if (idx == {14'h0000, `IVM_IDX_FLAGS_B}) begin
      d = {24'h00_0000, s.flag[13:6]};
    end else if (idx == {14'h0000, `IVM_IDX_FLAGS_C}) begin
      d = {30'h0000_0000, s.flag[15:14]};
    end else if (idx == {14'h0000, `IVM_IDX_INT_STATUS}) begin
      d = {16'h0000, s.status};
    end else if (idx == {14'h0000, `IVM_IDX_INT_MASK}) begin
      d = {16'h0000, s.mask};
    end
    return d;
  endfunction : readOf

  // ****************************************************************
  // bus control
  // ****************************************************************
  logic        addrPhase;
  logic        rdTake;
  logic        wrTake;

  assign addrPhase = hsel & htrans[1] & hready;
  assign rdTake    = addrPhase & ~hwrite;
  assign wrTake    = addrPhase & hwrite;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [15:0] rise;
    logic [15:0] clr;
    logic        fetchDone;
    rise      = 16'h0000;
    clr       = 16'h0000;
    fetchDone = 1'b0;
    st_next   = st_reg;

    // flags follow the live request level, no latching
    st_next.flag = flagNow;
    rise         = flagNow & ~st_reg.flag;

    // a write of one clears a status bit, but a new edge wins
    if (st_reg.wrPend && st_reg.wrIdx == `IVM_IDX_INT_STATUS) begin
      clr = hwdata[15:0];
    end
    st_next.status = (st_reg.status & ~clr) | rise;

    if (st_reg.wrPend && st_reg.wrIdx == `IVM_IDX_INT_MASK) begin
      st_next.mask = hwdata[15:0];
    end
    // flag registers have no write path, so writes there are dropped

    st_next.irq = |(st_next.status & st_next.mask);

    // zero wait states: read data is ready for the data phase
    st_next.hreadyout = 1'b1;
    st_next.hresp     = 1'b0;
    st_next.wrPend    = wrTake;
    st_next.wrIdx     = haddr[17:2];
    if (wrTake && haddr[31:18] != 14'h0000) begin
      st_next.wrIdx = 16'h0000;
    end
    if (rdTake) begin
      st_next.hrdata = readOf(haddr[31:2], st_reg);
    end

    // ****************************************************************
    // two-byte vector fetch
    // ****************************************************************
    st_next.vectorValid = 1'b0;
    st_next.memRd       = 1'b0;
    unique case (st_reg.fetch)
      ivm_pkg::FETCH_IDLE: begin
        if (vecFetchReq && winValid) begin
          st_next.fetchIdx = winIdx;
          st_next.memAddr  = vecOf(winIdx);
          st_next.memRd    = 1'b1;
          st_next.fetch    = ivm_pkg::FETCH_HI;
        end
      end
      ivm_pkg::FETCH_HI: begin
        st_next.memAddr = st_reg.memAddr + 16'h0001;
        st_next.memRd   = 1'b1;
        st_next.fetch   = ivm_pkg::FETCH_LO;
      end
      ivm_pkg::FETCH_LO: begin
        st_next.vecHi = memData;
        st_next.fetch = ivm_pkg::FETCH_LAST;
      end
      ivm_pkg::FETCH_LAST: begin
        st_next.vector      = {st_reg.vecHi, memData};
        st_next.vectorValid = 1'b1;
        st_next.fetch       = ivm_pkg::FETCH_IDLE;
        fetchDone           = 1'b1;
      end
    endcase

    // served software and reset requests retire; a fresh one still counts
    if (fetchDone && st_reg.fetchIdx == `IVM_SRC_RESET) begin
      st_next.resetPend = 1'b0;
    end
    if (fetchDone && st_reg.fetchIdx == `IVM_SRC_SWI) begin
      st_next.swiPend = 1'b0;
    end
    if (swiReq) begin
      st_next.swiPend = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg           <= '0;
      st_reg.flag      <= `IVM_RST_FLAGS;
      st_reg.status    <= `IVM_RST_STATUS;
      st_reg.mask      <= `IVM_RST_MASK;
      st_reg.resetPend <= 1'b1;
      st_reg.hreadyout <= 1'b1;
      st_reg.fetch     <= ivm_pkg::FETCH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata      = st_reg.hrdata;
  assign hreadyout   = st_reg.hreadyout;
  assign hresp       = st_reg.hresp;
  assign memAddr     = st_reg.memAddr;
  assign memRd       = st_reg.memRd;
  assign vector      = st_reg.vector;
  assign vectorValid = st_reg.vectorValid;
  assign irq         = st_reg.irq;

endmodule : interrupt_vector_map

/* File: ivm_map.svh */
`ifndef IVM_MAP_SVH
`define IVM_MAP_SVH

// ****************************************************************
// register indices: the byte address is four times the index
// ****************************************************************
`define IVM_IDX_FLAGS_A    16'hFE04
`define IVM_IDX_FLAGS_B    16'hFE05
`define IVM_IDX_FLAGS_C    16'hFE06
`define IVM_IDX_INT_STATUS 16'hFE10
`define IVM_IDX_INT_MASK   16'hFE11

// ****************************************************************
// reset values
// ****************************************************************
`define IVM_RST_FLAGS      16'h0000
`define IVM_RST_STATUS     16'h0000
`define IVM_RST_MASK       16'h0000

// ****************************************************************
// source index, lowest priority first; flag bit k holds index 15-k
// ****************************************************************
`define IVM_NUM_SRC        5'h12
`define IVM_SRC_SWI        5'h10
`define IVM_SRC_RESET      5'h11

// ****************************************************************
// vector locations, high byte at the even address
// ****************************************************************
`define IVM_VEC_TIMEBASE   16'hFFDC
`define IVM_VEC_SPI_TX     16'hFFDE
`define IVM_VEC_SPI_RX     16'hFFE0
`define IVM_VEC_ADC_DONE   16'hFFE2
`define IVM_VEC_KEYBOARD   16'hFFE4
`define IVM_VEC_SER_TX     16'hFFE6
`define IVM_VEC_SER_RX     16'hFFE8
`define IVM_VEC_SER_ERR    16'hFFEA
`define IVM_VEC_TB_OVF     16'hFFEC
`define IVM_VEC_TB_CH1     16'hFFEE
`define IVM_VEC_TB_CH0     16'hFFF0
`define IVM_VEC_TA_OVF     16'hFFF2
`define IVM_VEC_TA_CH1     16'hFFF4
`define IVM_VEC_TA_CH0     16'hFFF6
`define IVM_VEC_CLK_MON    16'hFFF8
`define IVM_VEC_EXT_IRQ    16'hFFFA
`define IVM_VEC_SWI        16'hFFFC
`define IVM_VEC_RESET      16'hFFFE

`endif

/* File: ivm_pkg.sv */
package ivm_pkg;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_HI,
    FETCH_LO,
    FETCH_LAST
  } fetch_state_t;

  typedef struct packed {
    logic [15:0]  flag;
    logic [15:0]  status;
    logic [15:0]  mask;
    logic         resetPend;
    logic         swiPend;
    logic         irq;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic         wrPend;
    logic [15:0]  wrIdx;
    fetch_state_t fetch;
    logic [4:0]   fetchIdx;
    logic [15:0]  memAddr;
    logic         memRd;
    logic [7:0]   vecHi;
    logic [15:0]  vector;
    logic         vectorValid;
  } ivm_state_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

endpackage : ivm_pkg

/* File: pin_sync.sv */
`timescale 1ns/1ps

// ****************************************************************
// two-stage synchroniser for an asynchronous pin level
// ****************************************************************
module pin_sync (
  input  wire logic clk,      // system clock
  input  wire logic srst,     // synchronous reset, active high
  input  wire logic pinIn,    // asynchronous level
  output logic      levelOut  // synchronised level
);

  ivm_pkg::sync_state_t st_reg;
  ivm_pkg::sync_state_t st_next;

  // stage1 feeds only stage2
  always_comb begin
    st_next        = st_reg;
    st_next.stage1 = pinIn;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign levelOut = st_reg.stage2;

endmodule : pin_sync

/* File: prio_pick.sv */
`timescale 1ns/1ps

// ****************************************************************
// picks the highest pending index; higher index wins
// ****************************************************************
module prio_pick (
  input  wire logic [17:0] req,      // pending requests, index 0 lowest
  output logic      [4:0]  winIdx,   // index of winner
  output logic             winValid  // any request pending
);

  always_comb begin
    winIdx   = 5'h00;
    winValid = 1'b0;
    for (int i = 0; i < 18; i++) begin
      if (req[i]) begin
        winIdx   = 5'(i);
        winValid = 1'b1;
      end
    end
  end

endmodule : prio_pick

/* File: ivm_checker.sv */
`timescale 1ns/1ps

// ****************************************************************
// port checker for the vector map
// ****************************************************************
module ivm_checker (
  input wire logic        clk,          // system clock
  input wire logic        srst,         // synchronous reset
  input wire logic        hreadyout,    // slave ready
  input wire logic        hresp,        // bus response
  input wire logic        memRd,        // byte read strobe
  input wire logic [15:0] memAddr,      // vector byte address
  input wire logic [15:0] vector,       // assembled vector
  input wire logic        vectorValid,  // completion pulse
  input wire logic        irq           // level interrupt
);
  // armed stays low on the edge where reset falls, so values sampled
  // before reset never reach a sampled-value function
  logic armed;
  always_ff @(posedge clk) begin
    armed <= ~srst;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !armed);

  a_fetch_walk: assert property ($rose(memRd) |=> memRd ##1 !memRd ##1 vectorValid)
    else $error("vector fetch walk broken");
  a_byte_order: assert property ($rose(memRd) |-> !memAddr[0] ##1
    memAddr == $past(memAddr) + 16'h0001)
    else $error("high byte not at even address");
  a_vec_window: assert property (memRd |-> memAddr >= 16'hFFDC)
    else $error("fetch below lowest vector");
  a_valid_pulse: assert property (vectorValid |=> !vectorValid)
    else $error("vector valid longer than one cycle");
  a_vec_hold: assert property ($changed(vector) |-> vectorValid)
    else $error("vector changed without completion");
  a_valid_cause: assert property (vectorValid |-> $past(memRd, 2) && $past(memRd, 3))
    else $error("vector valid without two byte reads");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_up: assert property (hreadyout)
    else $error("slave not ready");

  c_fetch: cover property (vectorValid);
  c_reset_vec: cover property ($rose(memRd) && memAddr == 16'hFFFE);
  c_irq: cover property ($rose(irq));
endmodule : ivm_checker

bind interrupt_vector_map ivm_checker chk (.clk(clk), .srst(srst), .hreadyout(hreadyout),
  .hresp(hresp), .memRd(memRd), .memAddr(memAddr), .vector(vector),
  .vectorValid(vectorValid), .irq(irq));

/* File: vec_mem_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// vector memory: byte answers the cycle after the strobe
// ****************************************************************
module vec_mem_model (
  input  wire logic        clk,      // system clock
  input  wire logic [15:0] memAddr,  // byte address
  input  wire logic        memRd,    // read strobe
  output logic      [7:0]  memData   // byte out
);
  initial memData = 8'h00;
  // outside a read the bus toggles so a stale byte never looks valid
  // a plain always: memData also takes a start value from the initial block
  always @(posedge clk) begin
    if (memRd) memData <= memAddr[7:0] ^ 8'h5A;
    else memData <= ~memData;
  end
endmodule : vec_mem_model

/* File: tb.sv */
`timescale 1ns/1ps
`include "ivm_map.svh"
module tb;
  logic        clk, srst, hsel, hwrite, extIrqPin, swiReq, vecFetchReq;
  logic        hreadyout, hresp, memRd, vectorValid, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [14:0] onChipReq;
  logic [15:0] memAddr, vector, fl;
  logic [7:0]  memData;
  wire         hready = hreadyout;
  int          n_errors, comparisons, k;

  interrupt_vector_map uut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extIrqPin(extIrqPin),
    .onChipReq(onChipReq), .swiReq(swiReq), .vecFetchReq(vecFetchReq),
    .memAddr(memAddr), .memRd(memRd), .memData(memData), .vector(vector),
    .vectorValid(vectorValid), .irq(irq));
  vec_mem_model mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memData(memData));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : mb

  // flag k sits two bytes below flag k-1; flag 1 just under the software vector
  function automatic logic [15:0] vaddr(input int n);
    return 16'hFFFC - 16'(2 * n);
  endfunction : vaddr

  function automatic int lowest(input logic [15:0] f);
    for (int i = 0; i < 16; i++) if (f[i]) return i + 1;
    return 0;
  endfunction : lowest

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdata);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {14'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : ahb

  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, idx, 32'h0, v);
    chk(nm, e, v);
  endtask : rdchk

  task automatic set_req(input logic [15:0] f);
    @(posedge clk);
    extIrqPin <= f[0];
    onChipReq <= f[15:1];
    repeat (6) @(posedge clk);
    #1;
  endtask : set_req

  task automatic chk_flags(input logic [15:0] f);
    rdchk("flags_a", `IVM_IDX_FLAGS_A, {24'h0, f[5:0], 2'b00});
    rdchk("flags_b", `IVM_IDX_FLAGS_B, {24'h0, f[13:6]});
    rdchk("flags_c", `IVM_IDX_FLAGS_C, {30'h0, f[15:14]});
  endtask : chk_flags

  task automatic fetch(input logic [15:0] a);
    int t;
    @(posedge clk) vecFetchReq <= 1'b1;
    @(posedge clk) vecFetchReq <= 1'b0;
    #1;
    for (t = 0; t < 20 && vectorValid !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
    chk("vectorValid", 32'h1, {31'h0, vectorValid});
    chk("vector", {16'h0, mb(a), mb(a + 16'h1)}, {16'h0, vector});
  endtask : fetch

  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hD452));
    srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; extIrqPin = 1'b0; onChipReq = 15'h0;
    swiReq = 1'b0; vecFetchReq = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_flags(16'h0);
    fetch(`IVM_VEC_RESET);
    @(posedge clk) swiReq <= 1'b1;
    @(posedge clk) swiReq <= 1'b0;
    fetch(`IVM_VEC_SWI);
    ahb(1'b1, `IVM_IDX_INT_MASK, 32'h0000FFFF, rd);
    for (k = 1; k <= 16; k++) begin
      set_req(16'h1 << (k - 1));
      fetch(vaddr(k));
    end
    // random mixes: flag layout, ignored writes and priority among several
    for (k = 0; k < 8; k++) begin
      fl = 16'($urandom);
      set_req(fl);
      chk_flags(fl);
      ahb(1'b1, `IVM_IDX_FLAGS_B, 32'h000000FF, rd);
      chk_flags(fl);
      if (fl != 16'h0) fetch(vaddr(lowest(fl)));
    end
    set_req(16'h0);
    ahb(1'b1, `IVM_IDX_INT_STATUS, 32'h0000FFFF, rd);
    repeat (2) @(posedge clk);
    #1 chk("irq idle", 32'h0, {31'h0, irq});
    set_req(16'h0010);
    chk("irq set", 32'h1, {31'h0, irq});
    set_req(16'h0);
    chk("irq sticky", 32'h1, {31'h0, irq});
    rdchk("status", `IVM_IDX_INT_STATUS, 32'h00000010);
    ahb(1'b1, `IVM_IDX_INT_STATUS, 32'h00000010, rd);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    ahb(1'b1, `IVM_IDX_INT_MASK, 32'h0, rd);
    set_req(16'h0010);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk("unmapped", 16'hFE20, 32'h0);
    end_sim();
  end
endmodule : tb
